// ==== hw/tcc_defs.svh ====
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// register offsets
`define TCC_OFS_INCFG        8'h31
`define TCC_OFS_SLEEP_BEGIN  8'h32
`define TCC_OFS_SLEEP_FINISH 8'h33
`define TCC_OFS_STRB_BEGIN   8'h34
`define TCC_OFS_STRB_FINISH  8'h35

// field positions in the input and clock config register, plus the top bit of the count registers
`define TCC_BIT_ISOLATE      10
`define TCC_BIT_CLAMP        5
`define TCC_DIV_HI           2
`define TCC_DIV_LO           0
`define TCC_CNT_HI           15

// reset values
`define TCC_RST_REG          24'h000000
`define TCC_RST_CNT          16'h0000
`define TCC_RST_CONNECT      1'b1
`define TCC_RST_RATIO        5'h02

`endif

// ==== hw/tcc_pkg.sv ====
package tcc_pkg;

    typedef logic [23:0] tcc_word_t;
    typedef logic [15:0] tcc_count_t;

    // register read or write request from the serial interface logic
    typedef struct packed {
        logic      wr;
        logic      rd;
        logic [7:0] addr;
        tcc_word_t wdata;
    } tcc_req_s;

    typedef enum logic [2:0] {
        TCC_DIV_2   = 3'b000,
        TCC_DIV_8   = 3'b001,
        TCC_DIV_BAD2 = 3'b010,
        TCC_DIV_12  = 3'b011,
        TCC_DIV_4   = 3'b100,
        TCC_DIV_1   = 3'b101,
        TCC_DIV_6   = 3'b110,
        TCC_DIV_BAD7 = 3'b111
    } tcc_div_e;

endpackage : tcc_pkg

// ==== hw/tcc_regs.sv ====
// Functional notes
// R1 - isolate bit 10 disconnects both photodiode inputs from the amplifier.
// R2 - while isolated, only the offset cancel current feeds the amplifier.
// R3 - while isolated, photodiode bias is switched off.
// R4 - clamp bit 5 ties amplifier inputs to common mode when amplifier off.
// R5 - bits 2..0 select external clock divider in external clock mode.
// R6 - codes map 0:2 1:8 3:12 4:4 5:1 6:6; codes 2, 7 forbidden.
// R7 - offset 32h holds 16-bit sleep window begin count, read/write.
// R8 - offset 33h holds 16-bit sleep window finish count, read/write.
// R9 - 16-bit field sets engine count where custom strobe begins.
// R10 - 16-bit field sets engine count where custom strobe ends.
// R11 - custom strobe may replace conversion-done signal on its output pin.
// R12 - strobe begin and finish fields are write-only; reads return zero.
// R13 - windows are high for begin <= count < finish.
`include "tcc_defs.svh"

module tcc_regs (
    // clock and reset
    input  wire logic             MCLK,
    input  wire logic             RST,
    // register access from the serial interface
    input  wire tcc_pkg::tcc_req_s REQ,
    output logic [23:0]           RDATA,
    // timing engine
    input  wire logic [15:0]      ENGINE_COUNT,
    input  wire logic             CONV_DONE,
    input  wire logic             STROBE_SEL,
    // analog front end controls
    output logic                  PD_POS_CONNECT,
    output logic                  PD_NEG_CONNECT,
    output logic                  PD_BIAS_EN,
    output logic                  OFFSET_CANCEL_ONLY,
    output logic                  INPUT_CLAMP_EN,
    output logic [4:0]            EXT_CLOCK_DIV_RATIO,
    output logic                  EXT_CLOCK_DIV_BAD,
    // timing outputs
    output logic                  SLEEP_WINDOW,
    output logic                  CONV_DONE_PIN
);

    ////////////////////////////////////////////////////////////////////////
    logic                photodiode_isolate_r;
    logic                pd_connect_r;
    logic                input_clamp_r;
    tcc_pkg::tcc_div_e   ext_clock_divider_sel_r;
    tcc_pkg::tcc_count_t sleep_window_begin_count_r;
    tcc_pkg::tcc_count_t sleep_window_finish_count_r;
    tcc_pkg::tcc_count_t custom_strobe_begin_count_r;
    tcc_pkg::tcc_count_t custom_strobe_finish_count_r;
    logic                strobe_r;
    logic                sleep_window_nxt;
    logic                strobe_nxt;
    logic [4:0]          ratio_nxt;
    logic [23:0]         rdata_nxt;
    logic                wr_incfg;
    logic                wr_sleep_begin;
    logic                wr_sleep_finish;
    logic                wr_strobe_begin;
    logic                wr_strobe_finish;
    tcc_pkg::tcc_count_t wr_count;

    ////////////////////////////////////////////////////////////////////////
    // one write enable per register; unknown offsets enable nothing
    always_comb begin
        wr_incfg         = REQ.wr && REQ.addr == `TCC_OFS_INCFG;
        wr_sleep_begin   = REQ.wr && REQ.addr == `TCC_OFS_SLEEP_BEGIN;
        wr_sleep_finish  = REQ.wr && REQ.addr == `TCC_OFS_SLEEP_FINISH;
        wr_strobe_begin  = REQ.wr && REQ.addr == `TCC_OFS_STRB_BEGIN;
        wr_strobe_finish = REQ.wr && REQ.addr == `TCC_OFS_STRB_FINISH;
        // upper byte of the count registers is dropped on purpose
        wr_count         = REQ.wdata[`TCC_CNT_HI:0];
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            photodiode_isolate_r <= 1'b0;
        else if (wr_incfg)
            photodiode_isolate_r <= REQ.wdata[`TCC_BIT_ISOLATE]; // [R1]
    end

    // inverted copy so connect and bias pins leave a flip-flop directly
    always_ff @(posedge MCLK) begin
        if (RST)
            pd_connect_r <= `TCC_RST_CONNECT;
        else if (wr_incfg)
            pd_connect_r <= !REQ.wdata[`TCC_BIT_ISOLATE]; // [R1] [R3]
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            input_clamp_r <= 1'b0;
        else if (wr_incfg)
            input_clamp_r <= REQ.wdata[`TCC_BIT_CLAMP]; // [R4]
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            ext_clock_divider_sel_r <= tcc_pkg::TCC_DIV_2;
        else if (wr_incfg)
            ext_clock_divider_sel_r <= tcc_pkg::tcc_div_e'(
                REQ.wdata[`TCC_DIV_HI:`TCC_DIV_LO]); // [R5]
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            sleep_window_begin_count_r <= `TCC_RST_CNT;
        else if (wr_sleep_begin)
            sleep_window_begin_count_r <= wr_count; // [R7]
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            sleep_window_finish_count_r <= `TCC_RST_CNT;
        else if (wr_sleep_finish)
            sleep_window_finish_count_r <= wr_count; // [R8]
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            custom_strobe_begin_count_r <= `TCC_RST_CNT;
        else if (wr_strobe_begin)
            custom_strobe_begin_count_r <= wr_count; // [R9]
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            custom_strobe_finish_count_r <= `TCC_RST_CNT;
        else if (wr_strobe_finish)
            custom_strobe_finish_count_r <= wr_count; // [R10]
    end

    ////////////////////////////////////////////////////////////////////////
    // read data registered; write-only counts read back as zero
    always_comb begin
        rdata_nxt = `TCC_RST_REG;
        unique case (REQ.addr)
            `TCC_OFS_INCFG: begin
                rdata_nxt[`TCC_BIT_CLAMP] = input_clamp_r;
                rdata_nxt[`TCC_DIV_HI:`TCC_DIV_LO] =
                    ext_clock_divider_sel_r;
            end
            `TCC_OFS_SLEEP_BEGIN:
                rdata_nxt[`TCC_CNT_HI:0] = sleep_window_begin_count_r; // [R7]
            `TCC_OFS_SLEEP_FINISH:
                rdata_nxt[`TCC_CNT_HI:0] = sleep_window_finish_count_r; // [R8]
            default: rdata_nxt = `TCC_RST_REG; // [R12]
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            RDATA <= `TCC_RST_REG;
        else if (REQ.rd)
            RDATA <= rdata_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // illegal codes fall back to divide-by-1 and raise a flag
    always_comb begin
        unique case (ext_clock_divider_sel_r)
            tcc_pkg::TCC_DIV_2:  ratio_nxt = 5'h02; // [R6]
            tcc_pkg::TCC_DIV_8:  ratio_nxt = 5'h08; // [R6]
            tcc_pkg::TCC_DIV_12: ratio_nxt = 5'h0c; // [R6]
            tcc_pkg::TCC_DIV_4:  ratio_nxt = 5'h04; // [R6]
            tcc_pkg::TCC_DIV_1:  ratio_nxt = 5'h01; // [R6]
            tcc_pkg::TCC_DIV_6:  ratio_nxt = 5'h06; // [R6]
            default:             ratio_nxt = 5'h01;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            EXT_CLOCK_DIV_RATIO <= `TCC_RST_RATIO;
        else
            EXT_CLOCK_DIV_RATIO <= ratio_nxt; // [R5]
    end

    // flag lets firmware spot a forbidden code that the decode hides
    always_ff @(posedge MCLK) begin
        if (RST)
            EXT_CLOCK_DIV_BAD <= 1'b0;
        else
            EXT_CLOCK_DIV_BAD <=
                ext_clock_divider_sel_r == tcc_pkg::TCC_DIV_BAD2 ||
                ext_clock_divider_sel_r == tcc_pkg::TCC_DIV_BAD7; // [R6]
    end

    ////////////////////////////////////////////////////////////////////////
    assign PD_POS_CONNECT     = pd_connect_r; // [R1]
    assign PD_NEG_CONNECT     = pd_connect_r; // [R1]
    assign OFFSET_CANCEL_ONLY = photodiode_isolate_r; // [R2]
    assign PD_BIAS_EN         = pd_connect_r; // [R3]
    assign INPUT_CLAMP_EN     = input_clamp_r; // [R4]

    ////////////////////////////////////////////////////////////////////////
    // windows registered so pins stay glitch free across counter steps
    // begin inclusive, finish exclusive; begin >= finish never opens
    always_comb begin
        sleep_window_nxt = ENGINE_COUNT >= sleep_window_begin_count_r &&
                           ENGINE_COUNT < sleep_window_finish_count_r;
        strobe_nxt       = ENGINE_COUNT >= custom_strobe_begin_count_r &&
                           ENGINE_COUNT < custom_strobe_finish_count_r;
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            SLEEP_WINDOW <= 1'b0;
        else
            SLEEP_WINDOW <= sleep_window_nxt; // [R13]
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            strobe_r <= 1'b0;
        else
            strobe_r <= strobe_nxt; // [R13]
    end

    always_ff @(posedge MCLK) begin
        if (RST)
            CONV_DONE_PIN <= 1'b0;
        else
            CONV_DONE_PIN <= STROBE_SEL ? strobe_r : CONV_DONE; // [R11]
    end

endmodule : tcc_regs

// ==== sim/tcc_regs_chk.sv ====
module tcc_regs_chk (
    // clock and reset
    input wire logic              MCLK,
    input wire logic              RST,
    // register access and sources
    input wire tcc_pkg::tcc_req_s REQ,
    input wire logic [23:0]       RDATA,
    input wire logic              CONV_DONE,
    input wire logic              STROBE_SEL,
    // watched outputs
    input wire logic              PD_POS_CONNECT,
    input wire logic              PD_NEG_CONNECT,
    input wire logic              PD_BIAS_EN,
    input wire logic              OFFSET_CANCEL_ONLY,
    input wire logic              INPUT_CLAMP_EN,
    input wire logic              EXT_CLOCK_DIV_BAD,
    input wire logic [4:0]        EXT_CLOCK_DIV_RATIO,
    input wire logic              CONV_DONE_PIN
);
    timeunit 1ns;
    timeprecision 1ps;
    // forbidden codes fall back to ratio 1
    localparam logic [4:0] rt [8] = '{5'h02, 5'h08, 5'h01, 5'h0c,
                                      5'h04, 5'h01, 5'h06, 5'h01};
    wire logic w31 = REQ.wr && REQ.addr == 8'h31;
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    a_iso_both: assert property (PD_POS_CONNECT == PD_NEG_CONNECT)
        else $error("inputs split");
    a_iso_offset: assert property (OFFSET_CANCEL_ONLY !=
        PD_POS_CONNECT) else $error("offset source wrong");
    a_iso_bias: assert property (PD_BIAS_EN == PD_POS_CONNECT)
        else $error("bias wrong");
    a_iso_write: assert property (w31 |=>
        PD_POS_CONNECT == !$past(REQ.wdata[10])) else $error("isolate");
    a_clamp_write: assert property (w31 |=>
        INPUT_CLAMP_EN == $past(REQ.wdata[5])) else $error("clamp");
    a_div_ratio: assert property (w31 ##1 !w31 |=>
        EXT_CLOCK_DIV_RATIO == rt[$past(REQ.wdata[2:0], 2)])
        else $error("ratio");
    a_div_bad: assert property (w31 ##1 !w31 |=> EXT_CLOCK_DIV_BAD ==
        ($past(REQ.wdata[2:0], 2) inside {3'h2, 3'h7})) else $error("bad");
    a_rd_zero: assert property (
        REQ.rd && !(REQ.addr inside {[8'h31:8'h33]}) ##1 !REQ.rd |=>
        RDATA == 24'h0) else $error("read not zero");
    a_conv_pass: assert property (!STROBE_SEL |=>
        CONV_DONE_PIN == $past(CONV_DONE)) else $error("conv pin");
    c_isolate: cover property (w31 && REQ.wdata[10]);
    c_strobe: cover property (STROBE_SEL && CONV_DONE_PIN);
    c_wo_read: cover property (REQ.rd && REQ.addr == 8'h34);
endmodule : tcc_regs_chk
////////////////////////////////////////////////////////////////
bind tcc_regs tcc_regs_chk u_chk (.MCLK(MCLK), .RST(RST), .REQ(REQ),
    .RDATA(RDATA), .CONV_DONE(CONV_DONE), .STROBE_SEL(STROBE_SEL),
    .PD_POS_CONNECT(PD_POS_CONNECT), .PD_NEG_CONNECT(PD_NEG_CONNECT),
    .PD_BIAS_EN(PD_BIAS_EN), .OFFSET_CANCEL_ONLY(OFFSET_CANCEL_ONLY),
    .INPUT_CLAMP_EN(INPUT_CLAMP_EN), .EXT_CLOCK_DIV_BAD(EXT_CLOCK_DIV_BAD),
    .EXT_CLOCK_DIV_RATIO(EXT_CLOCK_DIV_RATIO), .CONV_DONE_PIN(CONV_DONE_PIN));

// ==== sim/tcc_regs_test.sv ====
module tcc_regs_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] rt [8] = '{5'h02, 5'h08, 5'h01, 5'h0c,
                                      5'h04, 5'h01, 5'h06, 5'h01};
    logic              clk = 0, rst = 1, cdone = 0, ssel = 0;
    logic [15:0]       cnt = '0;
    tcc_pkg::tcc_req_s req = '0;
    logic [23:0]       rdata;
    logic              pp, pn, bias, ofs, clamp, bad, slp, pin;
    logic [4:0]        ratio;
    int                mismatches = 0, samples_checked = 0;
    tcc_regs uut (.MCLK(clk), .RST(rst), .REQ(req), .RDATA(rdata),
        .ENGINE_COUNT(cnt), .CONV_DONE(cdone), .STROBE_SEL(ssel),
        .PD_POS_CONNECT(pp), .PD_NEG_CONNECT(pn), .PD_BIAS_EN(bias),
        .OFFSET_CANCEL_ONLY(ofs), .INPUT_CLAMP_EN(clamp),
        .EXT_CLOCK_DIV_RATIO(ratio), .EXT_CLOCK_DIV_BAD(bad),
        .SLEEP_WINDOW(slp), .CONV_DONE_PIN(pin));
    always #10 clk = ~clk;
    task automatic chk(string n, logic [23:0] s, logic [23:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // a spare cycle after each access lets two-flop outputs such as ratio and bad update before the checks
    task automatic wr(logic [7:0] a, logic [23:0] d);
        req = '{1'b1, 1'b0, a, d};
        @(negedge clk);
        req.wr = 1'b0;
        @(negedge clk);
    endtask : wr
    task automatic rd(logic [7:0] a, logic [23:0] e);
        req = '{1'b0, 1'b1, a, 24'h0};
        @(negedge clk);
        req.rd = 1'b0;
        @(negedge clk);
        chk("rdata", rdata, e);
    endtask : rd
    task automatic test_done();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done
    task automatic t_reset();
        chk("reset", {pp, pn, bias, ofs, bad, ratio}, 10'h382);
        for (int a = 'h30; a <= 'h36; a++) begin
            rd(a[7:0], 24'h0);
        end
    endtask : t_reset
    task automatic t_input();
        wr(8'h31, 24'h000425);
        chk("iso", {pp, pn, bias, ofs}, 4'b0001);
        chk("clamp", clamp, 1'b1);
        rd(8'h31, 24'h000025);
        wr(8'h31, 24'h0);
        chk("iso", {pp, pn, bias, ofs, clamp}, 5'b11100);
    endtask : t_input
    task automatic t_div();
        for (int c = 0; c < 8; c++) begin
            wr(8'h31, {21'h0, c[2:0]});
            chk("ratio", ratio, rt[c]);
            chk("bad", bad, c == 2 || c == 7);
        end
    endtask : t_div
    task automatic t_sleep();
        wr(8'h32, 24'hff0010);
        wr(8'h33, 24'h000014);
        rd(8'h32, 24'h000010);
        rd(8'h33, 24'h000014);
        for (int c = 'h0e; c < 'h16; c++) begin
            cnt = c[15:0];
            @(negedge clk);
            chk("sleep", slp, c >= 'h10 && c < 'h14);
        end
    endtask : t_sleep
    task automatic t_strobe();
        wr(8'h34, 24'h000005);
        wr(8'h35, 24'h000007);
        rd(8'h34, 24'h0);
        rd(8'h35, 24'h0);
        ssel = 1'b1;
        for (int c = 4; c < 9; c++) begin
            cnt = c[15:0];
            repeat (2) @(negedge clk);
            chk("strobe", pin, c >= 5 && c < 7);
        end
        ssel = 1'b0;
        cdone = 1'b1;
        @(negedge clk);
        chk("pin", pin, 1'b1);
    endtask : t_strobe
    initial #200us begin
        mismatches++;
        test_done();
    end
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_input();
        t_div();
        t_sleep();
        t_strobe();
        test_done();
    end
endmodule : tcc_regs_test
